// ### core/svpo_cfg.svh
`ifndef SVPO_CFG_SVH
`define SVPO_CFG_SVH
`define SVPO_PIX_W 48
`define SVPO_COMP_W 16
`define SVPO_C0_TOP 47
`define SVPO_C1_TOP 31
`define SVPO_C2_TOP 15
`define SVPO_MAX_PPC 4
`define SVPO_CNT_W 16
`define SVPO_FMT_RST 2'h0
`define SVPO_BPC_RST 5'h08
`define SVPO_SYNC_RST 1'b0
`endif

// ### core/svpo_pkg.sv
package svpo_pkg;
	typedef enum logic [1:0] {
		SVPO_RGB = 2'h0,
		SVPO_YCC444 = 2'h1,
		SVPO_YCC422 = 2'h2,
		SVPO_LUMA = 2'h3
	} svpo_fmt_t;
	typedef enum logic [1:0] {
		SVPO_IDLE = 2'h0,
		SVPO_VSYNC = 2'h1,
		SVPO_BLANK = 2'h2,
		SVPO_ACTIVE = 2'h3
	} svpo_state_t;
	typedef logic [47:0] svpo_word_t;
endpackage : svpo_pkg

// ### core/svpo_lane_if.sv
interface svpo_lane_if;
	import svpo_pkg::*;
	logic [15:0] comp0;
	logic [15:0] comp1;
	logic [15:0] comp2;
	logic [4:0] bpc;
	svpo_fmt_t fmt;
	logic chromaSel;
	svpo_word_t word;
	modport packer (input comp0, comp1, comp2, bpc, fmt, chromaSel, output word);
	modport user (output comp0, comp1, comp2, bpc, fmt, chromaSel, input word);
endinterface : svpo_lane_if

// ### core/svpo_packer.sv
`include "svpo_cfg.svh"
module svpo_packer
	import svpo_pkg::*;
(
	svpo_lane_if.packer lane
);
	function automatic logic [15:0] msbAlign(input logic [15:0] v, input logic [4:0] bpc);
		logic [15:0] m;
		m = 16'hffff << (5'd16 - bpc);
		msbAlign = (v << (5'd16 - bpc)) & m;
	endfunction : msbAlign
	always_comb begin
		lane.word = '0;
		unique case (lane.fmt)
			SVPO_RGB, SVPO_YCC444: begin
				lane.word[`SVPO_C0_TOP -: 16] = msbAlign(lane.comp0, lane.bpc);
				lane.word[`SVPO_C1_TOP -: 16] = msbAlign(lane.comp1, lane.bpc);
				lane.word[`SVPO_C2_TOP -: 16] = msbAlign(lane.comp2, lane.bpc);
			end
			SVPO_YCC422: begin
				// Cr and Cb share the top group, alternating
				lane.word[`SVPO_C0_TOP -: 16] = msbAlign(lane.chromaSel ? lane.comp2 : lane.comp0,
					lane.bpc);
				lane.word[`SVPO_C1_TOP -: 16] = msbAlign(lane.comp1, lane.bpc);
			end
			SVPO_LUMA: begin
				lane.word[`SVPO_C0_TOP -: 16] = msbAlign(lane.comp1, lane.bpc);
			end
		endcase
	end
endmodule : svpo_packer

// ### core/svpo_pixel_port.sv
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Vsync pulse marks frame boundary
// - Back porch counts hsyncs after vsync
// - Front porch counts hsyncs before vsync
// - Vsync trailing edge resets data path
// - Horizontal porches counted in clocks
// - Pixels meaningful only while valid high
// - Valid may gap within a line
// - One, two or four pixels per clock
// - Second lane needs width and lanes
// - 48-bit word, MSB first, zero fill
// - Components at top of three groups
// - 422 alternates Cr/Cb in top group
//////////////////////////////////////////////////////////////////////////////
`include "svpo_cfg.svh"
module svpo_pixel_port
	import svpo_pkg::*;
#(
	parameter int PPC = 1
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Configuration
	input wire svpo_fmt_t fmt,
	input wire logic [4:0] bpc,
	input wire logic [2:0] laneCount,
	// Recovered stream
	input wire logic inVsync,
	input wire logic inHsync,
	input wire logic inValid,
	input wire logic [47:0] inComp0 [PPC],
	input wire logic [47:0] inComp1 [PPC],
	input wire logic [47:0] inComp2 [PPC],
	// User video output
	output logic vidVsync,
	output logic vidHsync,
	output logic vidValid,
	output svpo_word_t vidPixel [PPC],
	// Frame timing status
	output logic [15:0] vBackPorch,
	output logic [15:0] vFrontPorch,
	output logic [15:0] hBackPorch,
	output logic [15:0] hFrontPorch,
	output logic [15:0] lineCount
);
	svpo_state_t state_q;
	logic vsPrev_q, hsPrev_q;
	logic [15:0] hsCnt_q, vbpRun_q, vfpRun_q, clkCnt_q, lastValid_q;
	logic seenActive_q, lineActive_q, chroma_q;
	logic vsFall, vsRise, hsRise, hsFall, blank;
	svpo_word_t packed_w [PPC];

	//////////////////////////////////////////////////////////////////////////
	assign vsRise = inVsync & ~vsPrev_q;
	assign vsFall = ~inVsync & vsPrev_q;
	assign hsRise = inHsync & ~hsPrev_q;
	assign hsFall = ~inHsync & hsPrev_q;
	// Sync present or no frame yet: no pixel may escape
	assign blank = inVsync | inHsync | (state_q == SVPO_IDLE);

	function automatic logic laneOn(input int idx, input logic [2:0] lanes);
		laneOn = (idx == 0) || (lanes > 3'h1);
	endfunction : laneOn

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			vsPrev_q <= `SVPO_SYNC_RST;
			hsPrev_q <= `SVPO_SYNC_RST;
		end else begin
			vsPrev_q <= inVsync;
			hsPrev_q <= inHsync;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Frame state
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= SVPO_IDLE;
		end else if (vsRise) begin
			state_q <= SVPO_VSYNC;
		end else if (vsFall) begin
			state_q <= SVPO_BLANK;
		end else if (state_q == SVPO_BLANK && inValid && !blank) begin
			state_q <= SVPO_ACTIVE;
		end
	end

	// Vertical porches
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hsCnt_q <= '0;
			vbpRun_q <= '0;
			vfpRun_q <= '0;
			seenActive_q <= 1'b0;
			lineActive_q <= 1'b0;
			vBackPorch <= '0;
			vFrontPorch <= '0;
			lineCount <= '0;
		end else if (vsRise) begin
			vFrontPorch <= vfpRun_q;
		end else if (vsFall) begin
			// An hsync that rises with the vsync fall is still the first porch line
			vbpRun_q <= {15'h0, hsRise};
			vfpRun_q <= '0;
			hsCnt_q <= {15'h0, hsRise};
			seenActive_q <= 1'b0;
			lineActive_q <= 1'b0;
			lineCount <= '0;
		end else begin
			if (inValid && !blank && !lineActive_q) begin
				lineActive_q <= 1'b1;
				if (!seenActive_q) begin
					// The hsync opening this line belongs to it, not to the porch
					vBackPorch <= vbpRun_q - {15'h0, (vbpRun_q != 16'h0)};
				end
				seenActive_q <= 1'b1;
			end
			if (hsRise) begin
				hsCnt_q <= hsCnt_q + 16'h1;
				lineActive_q <= 1'b0;
				if (lineActive_q) begin
					lineCount <= lineCount + 16'h1;
					vfpRun_q <= 16'h1;
				end else if (seenActive_q) begin
					vfpRun_q <= vfpRun_q + 16'h1;
				end else begin
					vbpRun_q <= vbpRun_q + 16'h1;
				end
			end
		end
	end

	// Horizontal porches in clocks
	always_ff @(posedge mclk) begin
		if (!rst_n || vsFall) begin
			clkCnt_q <= '0;
			lastValid_q <= '0;
			hBackPorch <= '0;
			hFrontPorch <= '0;
		end else if (hsRise) begin
			clkCnt_q <= '0;
			if (lineActive_q) begin
				hFrontPorch <= clkCnt_q - lastValid_q;
			end
		end else begin
			clkCnt_q <= clkCnt_q + 16'h1;
			if (hsFall) begin
				clkCnt_q <= '0;
			end
			if (inValid && !blank) begin
				lastValid_q <= clkCnt_q + 16'h1;
				if (!lineActive_q) begin
					hBackPorch <= clkCnt_q;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// 4:2:2 chroma phase restarts each line so it always opens with Cr
	always_ff @(posedge mclk) begin
		if (!rst_n || vsFall || hsRise) begin
			chroma_q <= 1'b0;
		end else if (inValid && !blank) begin
			chroma_q <= chroma_q ^ PPC[0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < PPC; g++) begin : gLane
			svpo_lane_if lane ();
			assign lane.comp0 = inComp0[g][15:0];
			assign lane.comp1 = inComp1[g][15:0];
			assign lane.comp2 = inComp2[g][15:0];
			assign lane.bpc = bpc;
			assign lane.fmt = fmt;
			// Within a word, odd pixel positions carry Cb
			assign lane.chromaSel = chroma_q ^ 1'(g % 2);
			svpo_packer uPack (
				.lane(lane.packer)
			);
			assign packed_w[g] = lane.word;
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Registered outputs; pixel bus zeroed whenever valid is low
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			vidVsync <= `SVPO_SYNC_RST;
			vidHsync <= `SVPO_SYNC_RST;
			vidValid <= 1'b0;
			for (int i = 0; i < PPC; i++) begin
				vidPixel[i] <= '0;
			end
		end else begin
			vidVsync <= inVsync;
			vidHsync <= inHsync;
			// Gaps in inValid pass straight through on a fast clock
			vidValid <= inValid && !blank;
			for (int i = 0; i < PPC; i++) begin
				if (inValid && !blank && laneOn(i, laneCount)) begin
					vidPixel[i] <= packed_w[i];
				end else begin
					vidPixel[i] <= '0;
				end
			end
		end
	end
endmodule : svpo_pixel_port

// ### tb/svpo_pixel_port_asserts.sv
module svpo_pixel_port_asserts
	import svpo_pkg::*;
#(
	parameter int PPC = 1
)(
	// Clock, reset, setup
	input wire logic mclk,
	input wire logic rst_n,
	input wire svpo_fmt_t fmt,
	input wire logic [4:0] bpc,
	input wire logic [2:0] laneCount,
	// Stream in
	input wire logic inVsync,
	input wire logic inHsync,
	input wire logic inValid,
	// Video out
	input wire logic vidVsync,
	input wire logic vidHsync,
	input wire logic vidValid,
	input wire svpo_word_t vidPixel [PPC]
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	chk_valid_blank: assert property (vidValid |-> !vidVsync && !vidHsync)
		else $error("valid during sync");
	chk_valid_cause: assert property (vidValid |-> $past(inValid) && !$past(inVsync))
		else $error("valid without cause");
	chk_vsync_lag: assert property ($past(rst_n) |-> vidVsync == $past(inVsync))
		else $error("vsync not one cycle late");
	chk_hsync_lag: assert property ($past(rst_n) |-> vidHsync == $past(inHsync))
		else $error("hsync not one cycle late");
	chk_idle_zero: assert property (!vidValid |-> vidPixel[0] == 48'h0)
		else $error("pixel not zero when idle");
	chk_lane_gate: assert property (PPC > 1 && $past(laneCount) < 3'h2 |-> vidPixel[PPC-1] == 48'h0)
		else $error("second lane live on one lane");
	chk_msb_align: assert property (vidValid |-> 16'(vidPixel[0][47:32] << $past(bpc)) == 16'h0)
		else $error("top group not msb aligned");
	chk_luma_low: assert property (vidValid && $past(fmt) == SVPO_LUMA |-> vidPixel[0][31:0] == 32'h0)
		else $error("luma low groups not zero");
	chk_422_low: assert property (vidValid && $past(fmt) == SVPO_YCC422 |-> vidPixel[0][15:0] == 16'h0)
		else $error("422 low group not zero");
endmodule : svpo_pixel_port_asserts
bind svpo_pixel_port svpo_pixel_port_asserts #(.PPC(PPC)) svpo_pixel_port_asserts_inst (
	.mclk(mclk), .rst_n(rst_n), .fmt(fmt), .bpc(bpc), .laneCount(laneCount),
	.inVsync(inVsync), .inHsync(inHsync), .inValid(inValid), .vidVsync(vidVsync),
	.vidHsync(vidHsync), .vidValid(vidValid), .vidPixel(vidPixel));

// ### tb/svpo_user_sink.sv
module svpo_user_sink (
	// Clock and reset, free running
	input wire logic mclk,
	input wire logic rst_n,
	// Video from the port
	input wire logic vidVsync,
	input wire logic vidHsync,
	input wire logic vidValid,
	// Counts
	output logic [15:0] lineCnt_q,
	output logic [15:0] pixCnt_q
);
	logic vsPrev_q;
	logic hsPrev_q;
	always_ff @(posedge mclk) begin
		vsPrev_q <= vidVsync;
		hsPrev_q <= vidHsync;
	end
	always_ff @(posedge mclk) begin
		if (!rst_n || (vidVsync && !vsPrev_q)) lineCnt_q <= 16'h0;
		else if (vidHsync && !hsPrev_q) lineCnt_q <= lineCnt_q + 16'h1;
	end
	// Gaps in valid are simply skipped
	always_ff @(posedge mclk) begin
		if (!rst_n) pixCnt_q <= 16'h0;
		else if (vidValid) pixCnt_q <= pixCnt_q + 16'h1;
	end
endmodule : svpo_user_sink

// ### tb/tb.sv
module tb import svpo_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, inVsync, inHsync, inValid, vidVsync, vidHsync, vidValid;
	svpo_fmt_t fmt;
	logic [4:0] bpc;
	logic [2:0] laneCount;
	logic [47:0] inComp0 [2], inComp1 [2], inComp2 [2];
	svpo_word_t vidPixel [2], q0 [$], q1 [$];
	logic [15:0] lineCnt, pixCnt, vbp, vfp, hbp, hfp, lineNum;
	int fail_count, checked, np;
	int seed = 32'he260;
	bit seen;
	svpo_pixel_port #(.PPC(2)) svpo_pixel_port_inst (.mclk(mclk), .rst_n(rst_n), .fmt(fmt),
		.bpc(bpc), .laneCount(laneCount), .inVsync(inVsync), .inHsync(inHsync),
		.inValid(inValid), .inComp0(inComp0), .inComp1(inComp1), .inComp2(inComp2),
		.vidVsync(vidVsync), .vidHsync(vidHsync), .vidValid(vidValid), .vidPixel(vidPixel),
		.vBackPorch(vbp), .vFrontPorch(vfp), .hBackPorch(hbp), .hFrontPorch(hfp),
		.lineCount(lineNum));
	svpo_user_sink svpo_user_sink_inst (.mclk(mclk), .rst_n(rst_n), .vidVsync(vidVsync),
		.vidHsync(vidHsync), .vidValid(vidValid), .lineCnt_q(lineCnt), .pixCnt_q(pixCnt));
	initial begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	function automatic svpo_word_t pk(logic [15:0] a, y, c, bit odd);
		logic [4:0] s;
		s = 5'(16 - bpc);
		case (fmt)
			SVPO_YCC422: return {(odd ? c : a) << s, y << s, 16'h0};
			SVPO_LUMA: return {y << s, 32'h0};
			default: return {a << s, y << s, c << s};
		endcase
	endfunction : pk
	task cmp(svpo_word_t g, e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t pixel %h exp %h", $time, g, e);
		end
	endtask : cmp
	task cmpCnt(logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t count %0d exp %0d", $time, g, e);
		end
	endtask : cmpCnt
	task cyc(bit v, h, val);
		logic [15:0] a [2], y [2], c [2], m;
		@(posedge mclk);
		inVsync <= v;
		inHsync <= h;
		inValid <= val;
		seen |= v;
		m = (16'h1 << bpc) - 16'h1;
		for (int i = 0; i < 2; i++) begin
			a[i] = 16'($random(seed)) & m;
			y[i] = 16'($random(seed)) & m;
			c[i] = 16'($random(seed)) & m;
			inComp0[i] <= {32'h0, a[i]};
			inComp1[i] <= {32'h0, y[i]};
			inComp2[i] <= {32'h0, c[i]};
		end
		// Only pixels outside sync and after a frame start are expected
		if (val && !v && !h && seen) begin
			q0.push_back(pk(a[0], y[0], c[0], 0));
			q1.push_back(laneCount > 3'h1 ? pk(a[1], y[1], c[1], 1) : 48'h0);
			np++;
		end
	endtask : cyc
	task frame(svpo_fmt_t f, logic [4:0] b, logic [2:0] l);
		fmt <= f;
		bpc <= b;
		laneCount <= l;
		cyc(1, 0, 1);
		cyc(1, 0, 0);
		repeat (2) begin
			cyc(0, 1, 0);
			cyc(0, 0, 0);
		end
		repeat (3) begin
			cyc(0, 1, 1);
			for (int k = 0; k < 6; k++) cyc(0, 0, k != 2);
		end
		cyc(0, 1, 0);
		cyc(0, 0, 0);
	endtask : frame
	task finish_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////
	always @(negedge mclk) begin
		if (vidValid === 1'b1) begin
			if (q0.size() == 0) begin
				fail_count++;
				$display("MISMATCH %0t unexpected pixel", $time);
			end else begin
				cmp(vidPixel[0], q0.pop_front());
				cmp(vidPixel[1], q1.pop_front());
			end
		end
	end
	// Far beyond the roughly 130 cycles the sequence needs
	initial begin
		#20000;
		fail_count++;
		finish_test;
	end
	initial begin
		{inVsync, inHsync, inValid, rst_n} = 4'h0;
		fmt = SVPO_RGB;
		bpc = 5'h08;
		laneCount = 3'h2;
		inComp0 = '{default: 48'h0};
		inComp1 = '{default: 48'h0};
		inComp2 = '{default: 48'h0};
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) cyc(0, 0, 1);
		frame(SVPO_RGB, 5'h06, 3'h1);
		frame(SVPO_YCC444, 5'h0c, 3'h4);
		frame(SVPO_YCC422, 5'h08, 3'h2);
		frame(SVPO_LUMA, 5'h10, 3'h2);
		repeat (3) cyc(0, 0, 0);
		cmpCnt(pixCnt, 16'(np));
		cmpCnt(lineCnt, 16'h6);
		cmpCnt(16'(q0.size()), 16'h0);
		// Each frame: two blank lines, three active lines, one blank line
		cmpCnt(vbp, 16'h2);
		cmpCnt(vfp, 16'h1);
		cmpCnt(hbp, 16'h0);
		cmpCnt(hfp, 16'h0);
		cmpCnt(lineNum, 16'h3);
		finish_test;
	end
endmodule : tb
